//--- rtl/pscl_pkg.sv
// constants, types and carriers of the strap latch and mii front end
package pscl_pkg;

    // ==========================================================
    // register bus
    localparam int PSCL_AW = 4;
    localparam int PSCL_DW = 32;
    localparam logic [PSCL_AW-1:0] PSCL_OFF_CTRL = 4'h0;
    localparam logic [PSCL_AW-1:0] PSCL_OFF_STRAP = 4'h4;
    localparam int PSCL_CTRL_AN_BIT = 12;
    localparam int PSCL_CTRL_LOOP_BIT = 14;
    localparam int PSCL_ST_ADDR_LSB = 0;
    localparam int PSCL_ST_MODE_LSB = 8;
    localparam int PSCL_ST_XOVER_BIT = 12;
    localparam int PSCL_ST_B2B_BIT = 13;
    localparam int PSCL_ST_NAND_BIT = 16;
    localparam int PSCL_ST_EMI_BIT = 17;
    localparam int PSCL_ST_DONE_BIT = 31;

    // ==========================================================
    // strap defaults and mode codes
    localparam logic [4:0] PSCL_PHY_ADDR_DFLT = 5'h01;
    localparam logic [1:0] PSCL_PHY_ADDR_HI = 2'h0;
    localparam logic [2:0] PSCL_MODE_NORMAL = 3'h0;
    localparam logic [2:0] PSCL_MODE_XOVER = 3'h2;
    localparam logic [2:0] PSCL_MODE_B2B = 3'h6;
    // two synchroniser stages plus one margin cycle
    localparam logic [1:0] PSCL_SETTLE_CYC = 2'h3;

    // ==========================================================
    // types
    typedef enum logic [2:0]
    {
        PSCL_HOLD = 3'b001,
        PSCL_SETTLE = 3'b010,
        PSCL_RUN = 3'b100
    } pscl_state_e;

    typedef struct packed
    {
        logic rxc;
        logic crs;
        logic dv;
        logic er;
        logic [3:0] rxd;
    } pscl_rxpin_s;

    typedef struct packed
    {
        logic crs;
        logic dv;
        logic er;
        logic [3:0] data;
    } pscl_linerx_s;

    typedef struct packed
    {
        logic en;
        logic [3:0] data;
    } pscl_tx_s;

    typedef struct packed
    {
        logic [4:0] phy_addr;
        logic [2:0] mode;
        logic xover_en;
        logic b2b_en;
        logic nand_tree_en;
        logic emi_filter_en;
    } pscl_cfg_s;

endpackage : pscl_pkg

//--- rtl/pscl_top.sv
// strap capture, register slave and mii nibble front end
//
// The implementer's own choices: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module pscl_top
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic link_clk,
    // avalon-mm slave
    input wire logic [pscl_pkg::PSCL_AW-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [pscl_pkg::PSCL_DW-1:0] avs_writedata,
    output logic [pscl_pkg::PSCL_DW-1:0] avs_readdata,
    output logic avs_waitrequest,
    // shared receive / strap pins
    input wire pscl_pkg::pscl_rxpin_s rx_pin_i,
    output pscl_pkg::pscl_rxpin_s rx_pin_o,
    output pscl_pkg::pscl_rxpin_s rx_pin_oe,
    // shared interrupt / nand-tree strap pin, open drain
    input wire logic interrupt_out_i,
    output logic interrupt_out_o,
    output logic interrupt_out_oe,
    // transmit pins from the mac
    output logic tx_clk_o,
    input wire pscl_pkg::pscl_tx_s tx_pin_i,
    // line side, link clock domain
    input wire pscl_pkg::pscl_linerx_s line_rx_i,
    output logic line_rx_take_o,
    output pscl_pkg::pscl_tx_s line_tx_o,
    output logic line_tx_valid_o,
    // latched configuration, clk domain
    output pscl_pkg::pscl_cfg_s cfg_o,
    output logic disable_strap_a_en_o,
    output logic strap_done_o
);
    import pscl_pkg::*;

    // ==========================================================
    // system clock domain state
    typedef struct packed
    {
        pscl_state_e state;
        logic [1:0] cnt;
        pscl_rxpin_s pin_s1;
        pscl_rxpin_s pin_s2;
        logic int_s1;
        logic int_s2;
        // no interrupt source: both flops hold the released pin
        logic int_o;
        logic int_oe;
        pscl_cfg_s cfg;
        logic disable_strap_a_en;
        logic loop_en;
        logic run;
        pscl_rxpin_s oe;
        logic wait_r;
        logic [PSCL_DW-1:0] rdata;
    } pscl_sys_s;

    pscl_sys_s s_q;
    pscl_sys_s s_d;

    logic req;
    logic [PSCL_DW-1:0] ctrl_word;
    logic [PSCL_DW-1:0] strap_word;

    always_comb
    begin
        req = avs_read | avs_write;
        ctrl_word = '0;
        ctrl_word[PSCL_CTRL_AN_BIT] = s_q.disable_strap_a_en;
        ctrl_word[PSCL_CTRL_LOOP_BIT] = s_q.loop_en;
        strap_word = '0;
        strap_word[PSCL_ST_ADDR_LSB +: 5] = s_q.cfg.phy_addr;
        strap_word[PSCL_ST_MODE_LSB +: 3] = s_q.cfg.mode;
        strap_word[PSCL_ST_XOVER_BIT] = s_q.cfg.xover_en;
        strap_word[PSCL_ST_B2B_BIT] = s_q.cfg.b2b_en;
        strap_word[PSCL_ST_NAND_BIT] = s_q.cfg.nand_tree_en;
        strap_word[PSCL_ST_EMI_BIT] = s_q.cfg.emi_filter_en;
        strap_word[PSCL_ST_DONE_BIT] = s_q.run;

        s_d = s_q;
        // pins are asynchronous to clk: two stages before any use
        s_d.pin_s1 = rx_pin_i;
        s_d.pin_s2 = s_q.pin_s1;
        s_d.int_s1 = interrupt_out_i;
        s_d.int_s2 = s_q.int_s1;

        case (s_q.state)
            PSCL_HOLD:
            begin
                // pins stay released while straps settle
                s_d.oe = '0;
                s_d.cnt = PSCL_SETTLE_CYC;
                s_d.state = PSCL_SETTLE;
            end
            PSCL_SETTLE:
            begin
                s_d.cnt = s_q.cnt - 2'h1;
                if (s_q.cnt == 2'h1)
                begin
                    // capture once the synchronisers hold reset-time levels
                    s_d.cfg.phy_addr = {PSCL_PHY_ADDR_HI,
                        s_q.pin_s2.rxd[1], s_q.pin_s2.rxd[2],
                        s_q.pin_s2.rxd[3]};
                    // mode code from dv, crs, rxc
                    s_d.cfg.mode = {s_q.pin_s2.dv, s_q.pin_s2.crs,
                        s_q.pin_s2.rxc};
                    s_d.cfg.xover_en =
                        ({s_q.pin_s2.dv, s_q.pin_s2.crs, s_q.pin_s2.rxc}
                        == PSCL_MODE_XOVER) |
                        ({s_q.pin_s2.dv, s_q.pin_s2.crs, s_q.pin_s2.rxc}
                        == PSCL_MODE_B2B);
                    // reserved codes get no special handling
                    s_d.cfg.b2b_en =
                        {s_q.pin_s2.dv, s_q.pin_s2.crs, s_q.pin_s2.rxc}
                        == PSCL_MODE_B2B;
                    // strap inverted into control bit 12
                    s_d.disable_strap_a_en = ~s_q.pin_s2.rxd[0];
                    // low interrupt strap selects nand tree
                    s_d.cfg.nand_tree_en = ~s_q.int_s2;
                    s_d.cfg.emi_filter_en = ~s_q.pin_s2.er;
                    s_d.run = 1'b1;
                    s_d.oe = '1;
                    s_d.state = PSCL_RUN;
                end
            end
            PSCL_RUN:
            begin
                // no path back, captured cfg holds until reset; control bit 12 stays bus-writable
                s_d.state = PSCL_RUN;
            end
            default:
            begin
                s_d.state = PSCL_HOLD;
            end
        endcase

        // avalon slave: one wait cycle, answer at the second edge
        s_d.wait_r = ~(req & s_q.wait_r);
        if (req && s_q.wait_r)
        begin
            case (avs_address)
                PSCL_OFF_CTRL: s_d.rdata = ctrl_word;
                PSCL_OFF_STRAP: s_d.rdata = strap_word;
                default: s_d.rdata = '0;
            endcase
        end
        if (avs_write && !s_q.wait_r && avs_address == PSCL_OFF_CTRL)
        begin
            // a bit 12 write before the capture cycle is overwritten by the strap; in that cycle the write wins
            s_d.disable_strap_a_en = avs_writedata[PSCL_CTRL_AN_BIT];
            s_d.loop_en = avs_writedata[PSCL_CTRL_LOOP_BIT];
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            s_q.state <= PSCL_HOLD;
            s_q.cnt <= '0;
            s_q.pin_s1 <= '0;
            s_q.pin_s2 <= '0;
            s_q.int_s1 <= 1'b0;
            s_q.int_s2 <= 1'b0;
            s_q.int_o <= 1'b0;
            s_q.int_oe <= 1'b0;
            s_q.cfg.phy_addr <= PSCL_PHY_ADDR_DFLT;
            s_q.cfg.mode <= PSCL_MODE_NORMAL;
            s_q.cfg.xover_en <= 1'b0;
            s_q.cfg.b2b_en <= 1'b0;
            s_q.cfg.nand_tree_en <= 1'b0;
            s_q.cfg.emi_filter_en <= 1'b1;
            s_q.disable_strap_a_en <= 1'b0;
            s_q.loop_en <= 1'b0;
            s_q.run <= 1'b0;
            s_q.oe <= '0;
            s_q.wait_r <= 1'b1;
            s_q.rdata <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // ==========================================================
    // link clock domain state
    typedef struct packed
    {
        logic run_s1;
        logic run_s2;
        logic loop_s1;
        logic loop_s2;
        pscl_tx_s tx_s1;
        pscl_tx_s tx_s2;
        pscl_rxpin_s rx;
        logic tx_clk;
        logic take;
        pscl_tx_s tx_out;
        logic tx_valid;
    } pscl_link_s;

    pscl_link_s l_q;
    pscl_link_s l_d;

    always_comb
    begin
        l_d = l_q;
        // levels from the clk domain, two-stage synchronised
        l_d.run_s1 = s_q.run;
        l_d.run_s2 = l_q.run_s1;
        l_d.loop_s1 = s_q.loop_en;
        l_d.loop_s2 = l_q.loop_s1;
        // mac pins arrive on our tx clock but pass two stages anyway
        l_d.tx_s1 = tx_pin_i;
        l_d.tx_s2 = l_q.tx_s1;
        l_d.take = 1'b0;
        l_d.tx_valid = 1'b0;
        // mii clocks are link_clk halved; both from one phase flop
        l_d.rx.rxc = ~l_q.rx.rxc & l_q.run_s2;
        l_d.tx_clk = ~l_q.rx.rxc & l_q.run_s2;
        if (!l_q.run_s2)
        begin
            l_d.rx = '0;
        end
        else if (l_q.rx.rxc)
        begin
            // rx nibble changes on falling rxc, stable at rising
            if (l_q.loop_s2)
            begin
                l_d.rx.rxd = l_q.tx_s2.data;
                l_d.rx.dv = l_q.tx_s2.en;
                l_d.rx.crs = l_q.tx_s2.en;
                l_d.rx.er = 1'b0;
            end
            else
            begin
                l_d.rx.rxd = line_rx_i.data;
                l_d.rx.dv = line_rx_i.dv;
                l_d.rx.crs = line_rx_i.crs;
                l_d.rx.er = line_rx_i.er;
                l_d.take = 1'b1;
            end
        end
        else
        begin
            // tx nibble accepted only while tx enable is high
            if (l_q.tx_s2.en)
            begin
                l_d.tx_out = l_q.tx_s2;
                l_d.tx_valid = 1'b1;
            end
        end
    end

    always_ff @(posedge link_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            l_q <= '0;
        end
        else
        begin
            l_q <= l_d;
        end
    end

    // ==========================================================
    // outputs, all straight from flops
    assign avs_readdata = s_q.rdata;
    assign avs_waitrequest = s_q.wait_r;
    assign rx_pin_o = l_q.rx;
    assign rx_pin_oe = s_q.oe;
    // no interrupt source here: open-drain pin stays released
    assign interrupt_out_o = s_q.int_o;
    assign interrupt_out_oe = s_q.int_oe;
    assign tx_clk_o = l_q.tx_clk;
    assign line_rx_take_o = l_q.take;
    assign line_tx_o = l_q.tx_out;
    assign line_tx_valid_o = l_q.tx_valid;
    assign cfg_o = s_q.cfg;
    assign disable_strap_a_en_o = s_q.disable_strap_a_en;
    assign strap_done_o = s_q.run;

endmodule : pscl_top

`default_nettype wire

//--- sim/pscl_props.sv
// port assertions of the strap latch
`timescale 1ns/1ps
`default_nettype none
module pscl_props
    import pscl_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic avs_waitrequest,
    input wire pscl_pkg::pscl_rxpin_s rx_pin_oe,
    input wire pscl_pkg::pscl_cfg_s cfg_o,
    input wire logic strap_done_o
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    // ====
    // bus answer
    sequence s_req;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    sequence s_ack;
        !avs_waitrequest ##1 avs_waitrequest;
    endsequence
    bus_ack_a:
        assert property (s_req |=> s_ack)
        else $error("bus answer wrong");
    // ====
    // strap pins and latch
    oe_reset_a:
        assert property (!strap_done_o |-> rx_pin_oe == '0)
        else $error("pins driven early");
    oe_run_a:
        assert property (strap_done_o |-> rx_pin_oe == '1)
        else $error("pins not driven");
    done_keep_a:
        assert property (strap_done_o |=> strap_done_o)
        else $error("done dropped");
    cfg_keep_a:
        assert property ($past(strap_done_o) |-> $stable(cfg_o))
        else $error("config changed");
    addr_hi_a:
        assert property (cfg_o.phy_addr[4:3] == PSCL_PHY_ADDR_HI)
        else $error("address high bits set");
    dflt_cfg_a:
        assert property (!strap_done_o |->
            cfg_o.phy_addr == PSCL_PHY_ADDR_DFLT && cfg_o.mode == '0)
        else $error("default config wrong");
    xover_a:
        assert property (cfg_o.xover_en == (cfg_o.mode == PSCL_MODE_XOVER
            || cfg_o.mode == PSCL_MODE_B2B))
        else $error("crossover wrong");
    b2b_a:
        assert property (cfg_o.b2b_en == (cfg_o.mode == PSCL_MODE_B2B))
        else $error("back to back wrong");
endmodule : pscl_props
bind pscl_top pscl_props i_props (.clk(clk), .rst_b(rst_b),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_waitrequest(avs_waitrequest), .rx_pin_oe(rx_pin_oe),
    .cfg_o(cfg_o), .strap_done_o(strap_done_o));
`default_nettype wire

//--- sim/pscl_mac.sv
// mac model at the mii pins
`timescale 1ns/1ps
`default_nettype none
module pscl_mac
    import pscl_pkg::*;
(
    input wire logic link_clk,
    input wire logic tx_clk_o,
    input wire pscl_pkg::pscl_rxpin_s rx_pin,
    output var pscl_pkg::pscl_tx_s tx_pin
);
    logic rxc_q;
    logic [3:0] got_q [$];
    initial tx_pin = '0;
    // take nibble on rx clock rise
    always @(posedge link_clk)
    begin
        rxc_q <= rx_pin.rxc;
        if (rx_pin.rxc && !rxc_q && rx_pin.dv)
            got_q.push_back(rx_pin.rxd);
    end
    // one nibble per tx clock, idle data inverted
    task automatic send(input logic [3:0] n);
        logic p;
        p = 1'b1;
        for (int t = 0; t < 8; t++)
        begin
            @(posedge link_clk);
            if (tx_clk_o && !p)
                break;
            p = tx_clk_o;
        end
        tx_pin <= '{en: 1'b1, data: n};
        repeat (2) @(posedge link_clk);
        tx_pin <= '{en: 1'b0, data: ~n};
    endtask : send
endmodule : pscl_mac
`default_nettype wire

//--- sim/tb_top.sv
// strap latch bench: straps, registers and mii nibbles
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import pscl_pkg::*;
    logic clk, lclk, rst_b, rd, wr, wq, io, ioe, ii, ns, txc, tk, tv, an, dn;
    logic [3:0] adr;
    logic [2:0] m;
    logic [2:0] md [3];
    logic [31:0] wd, rdat, g, x;
    pscl_rxpin_s pin, po, poe, st;
    pscl_tx_s txp, ltx;
    pscl_linerx_s lrx;
    pscl_cfg_s cfg, ec;
    int fail_count, total_checks, seed, i, j, k;
    // pulls hold the straps while the pins are released
    assign pin = (poe & po) | (~poe & st);
    assign ii = ioe ? io : ns;
    pscl_top i_dut (.clk(clk), .rst_b(rst_b), .link_clk(lclk),
        .avs_address(adr), .avs_read(rd), .avs_write(wr),
        .avs_writedata(wd), .avs_readdata(rdat), .avs_waitrequest(wq),
        .rx_pin_i(pin), .rx_pin_o(po), .rx_pin_oe(poe),
        .interrupt_out_i(ii), .interrupt_out_o(io),
        .interrupt_out_oe(ioe), .tx_clk_o(txc), .tx_pin_i(txp),
        .line_rx_i(lrx), .line_rx_take_o(tk), .line_tx_o(ltx),
        .line_tx_valid_o(tv), .cfg_o(cfg), .disable_strap_a_en_o(an),
        .strap_done_o(dn));
    pscl_mac i_mac (.link_clk(lclk), .tx_clk_o(txc), .rx_pin(pin),
        .tx_pin(txp));
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial
    begin
        lclk = 1'b0;
        #7;
        forever #40 lclk = ~lclk;
    end
    // ====
    // expectations
    function automatic pscl_cfg_s exp_cfg(pscl_rxpin_s s, logic n);
        logic [2:0] c;
        c = {s.dv, s.crs, s.rxc};
        return '{phy_addr: {PSCL_PHY_ADDR_HI, s.rxd[1], s.rxd[2], s.rxd[3]},
            mode: c, xover_en: c == PSCL_MODE_XOVER || c == PSCL_MODE_B2B,
            b2b_en: c == PSCL_MODE_B2B, nand_tree_en: !n,
            emi_filter_en: !s.er};
    endfunction : exp_cfg
    function automatic logic [31:0] sreg(pscl_cfg_s c);
        logic [31:0] r;
        r = '0;
        r[PSCL_ST_ADDR_LSB +: 5] = c.phy_addr;
        r[PSCL_ST_MODE_LSB +: 3] = c.mode;
        r[PSCL_ST_XOVER_BIT] = c.xover_en;
        r[PSCL_ST_B2B_BIT] = c.b2b_en;
        r[PSCL_ST_NAND_BIT] = c.nand_tree_en;
        r[PSCL_ST_EMI_BIT] = c.emi_filter_en;
        r[PSCL_ST_DONE_BIT] = 1'b1;
        return r;
    endfunction : sreg
    // ====
    // shared tasks
    task automatic conclude;
        $display("checks %0d fails %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : conclude
    task automatic chk(input logic [31:0] a, input logic [31:0] e);
        total_checks++;
        if (a !== e)
        begin
            fail_count++;
            $display("[FAIL] %0t got %h exp %h", $time, a, e);
        end
    endtask : chk
    // a used-up wait counts as a mismatch
    task automatic lim(input int n);
        chk({31'h0, n > 19}, 32'h0);
        if (n > 19)
            conclude();
    endtask : lim
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        rd <= !w;
        wr <= w;
        adr <= a;
        wd <= d;
        for (k = 0; k < 20; k++)
        begin
            @(posedge clk);
            if (wq === 1'b0)
                break;
        end
        lim(k);
        g = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask : bus
    // a high rx clock proves the link runs; a stuck low one would not
    task automatic rxs(input logic [3:0] n, input logic v);
        for (k = 0; k < 20; k++)
        begin
            @(posedge lclk);
            if (po.rxc === 1'b1)
                break;
        end
        lim(k);
        @(posedge lclk);
        chk({31'h0, tk}, 32'h1);
        lrx <= '{crs: v, dv: v, er: 1'b0, data: n};
    endtask : rxs
    // ====
    // main sequence, each pass a fresh reset
    initial
    begin
        seed = 18;
        {rst_b, rd, wr, ns, adr, wd, st, lrx} = '0;
        md = '{PSCL_MODE_NORMAL, PSCL_MODE_XOVER, PSCL_MODE_B2B};
        for (i = 0; i < 6; i++)
        begin
            @(posedge clk);
            rst_b <= 1'b0;
            g = $random(seed);
            m = md[i % 3];
            // only defined mode codes are strapped
            st <= {m[0], m[1], m[2], g[4:0]};
            ns <= g[5];
            repeat (5) @(posedge clk);
            rst_b <= 1'b1;
            for (k = 0; k < 20 && dn !== 1'b1; k++)
                @(posedge clk);
            lim(k);
            ec = exp_cfg(st, ns);
            chk({20'h0, cfg}, {20'h0, ec});
            chk({31'h0, an}, {31'h0, !st.rxd[0]});
            chk({30'h0, io, ioe}, 32'h0);
            bus(1'b0, PSCL_OFF_STRAP, '0);
            chk(g, sreg(ec));
            bus(1'b0, PSCL_OFF_CTRL, '0);
            chk(g, {19'h0, !st.rxd[0], 12'h0});
            x = $random(seed);
            for (j = 0; j < 3; j++)
                rxs(x[j*4 +: 4], 1'b1);
            rxs(~x[11:8], 1'b0);
            repeat (4) @(posedge lclk);
            for (j = 0; j < 3; j++)
                chk({28'h0, i_mac.got_q.pop_front()}, {28'h0, x[j*4 +: 4]});
            chk(i_mac.got_q.size(), 0);
            for (j = 0; j < 3; j++)
            begin
                i_mac.send(x[16+j*4 +: 4]);
                for (k = 0; k < 20 && tv !== 1'b1; k++)
                    @(posedge lclk);
                lim(k);
                chk({28'h0, ltx.data}, {28'h0, x[16+j*4 +: 4]});
            end
            k = 0;
            repeat (8)
            begin
                @(posedge lclk);
                if (tv !== 1'b0)
                    k++;
            end
            chk(k, 0);
            chk({20'h0, cfg}, {20'h0, ec});
            bus(1'b1, PSCL_OFF_STRAP, '1);
            bus(1'b0, PSCL_OFF_STRAP, '0);
            chk(g, sreg(ec));
            bus(1'b0, 4'h8, '0);
            chk(g, 32'h0);
            bus(1'b1, PSCL_OFF_CTRL, x);
            bus(1'b0, PSCL_OFF_CTRL, '0);
            chk(g, x & 32'h5000);
            bus(1'b1, PSCL_OFF_CTRL, 32'h1 << PSCL_CTRL_LOOP_BIT);
            repeat (4) @(posedge lclk);
            i_mac.send(x[23:20]);
            repeat (6) @(posedge lclk);
            chk(i_mac.got_q.size(), 1);
            chk({28'h0, i_mac.got_q.pop_front()}, {28'h0, x[23:20]});
            $display("test %0d done", i);
        end
        conclude();
    end
endmodule : tb_top
`default_nettype wire
